/* core/crsf_supervisor.sv */
// Core rail supervisor: rail-low freeze, power-up fail-safe and board-test tree
// How it works
// - Rail-low handling acts only while enable bit one of register 0x36 is set.
// - Rail below its low limit sets status bit one.
// - Rail-low drives the alert pin only when that alert source is enabled.
// - Rail low suspends thermal monitoring; thermal timer holds its count.
// - Rail low freezes dynamic fan-start temperature adjustment.
// - Rail low blocks entry into shutdown, even when requested.
// - Rail back above limit re-enables everything suspended.
// - Bit zero of register 0x6F selects the XNOR board-test chain.
// - Base variant polls the rail at power-up; option starts with fans running.
// - Rail unpowered at power-up: stay idle until addressed, then load defaults.
// - Rail powered at power-up starts countdown; expiry forces fans full speed.
// - After full speed, first address stops fans, loads defaults, runs normally.
// - Host addressing before expiry gives normal operation, never full speed.
module crsf_supervisor
#(
	parameter bit FANS_ON_AT_POWERUP = 1'b0,                      // Variant: skip rail poll
	parameter int FAILSAFE_CYCLES    = crsf_pkg::FAILSAFE_CYCLES, // Countdown length
	parameter int TEST_PINS          = 8                          // Pins in XNOR chain
)
(
	input  wire logic                 clk,                   // 100 MHz clock
	input  wire logic                 rst_b,                 // Power-on reset, active low
	input  wire logic                 reg_wr,                // Register write strobe
	input  wire logic                 reg_rd,                // Register read strobe
	input  wire logic [7:0]           reg_addr,              // Register offset
	input  wire logic [7:0]           reg_wdata,             // Write data
	output logic      [7:0]           reg_rdata,             // Read data, next cycle
	input  wire logic                 smbus_addr_match,      // Valid transaction addressed us
	input  wire logic [7:0]           core_rail_voltage,     // Rail reading
	input  wire logic [7:0]           core_rail_low_limit,   // Rail low limit
	input  wire logic                 core_rail_present,     // Rail above 0.75 V, async
	input  wire logic                 status_clear,          // Clear status flag
	input  wire logic                 alert_enable,          // Alert source enabled
	input  wire logic                 shutdown_request,      // Shutdown wanted
	input  wire logic [TEST_PINS-1:0] test_pins,             // Pins of the XNOR chain
	output logic      [7:0]           status_one,            // First status register
	output logic                      smbus_alert_out,       // Alert pin level
	output logic                      smbus_alert_oe,        // Alert pin pulled low
	output logic                      thermal_monitor_enable,// Thermal input monitoring on
	output logic                      thermal_timer_hold,    // Thermal timer frozen
	output logic                      dyn_fan_start_temperature_adjust_enable,// Fan-start temp adaptation on
	output logic                      shutdown_active,       // Device in shutdown
	output logic                      fan_full_speed,        // Fans forced full speed
	output logic                      load_defaults,         // One-cycle default load
	output logic                      normal_operation,      // Normal operation running
	output logic                      board_test_mode,       // XNOR test mode on
	output logic                      xnor_tree_out          // XNOR chain result
);

	logic [7:0]               dyn_fan_start_temperature_control_one_reg;
	logic [7:0]               board_test_enable_reg;
	logic [7:0]               reg_rdata_reg;
	logic                     present_meta_reg;
	logic                     present_sync_reg;
	logic [TEST_PINS-1:0]     pins_meta_reg;
	logic [TEST_PINS-1:0]     pins_sync_reg;
	logic                     rail_low_reg;
	logic                     status_flag_reg;
	logic                     alert_oe_reg;
	logic                     thermal_en_reg;
	logic                     fan_start_temperature_adj_reg;
	logic                     shutdown_reg;
	logic                     full_speed_reg;
	logic                     load_defaults_reg;
	logic                     normal_reg;
	logic                     test_mode_reg;
	logic                     xnor_reg;
	logic [1:0]               settle_reg;
	logic                     rail_low_next;
	crsf_pkg::crsf_pu_state_t pu_state_reg;
	crsf_pkg::crsf_pu_state_t pu_state_next;
	crsf_timer_if             tif ();

	crsf_failsafe_timer
	#(
		.CYCLES (FAILSAFE_CYCLES)
	)
	u_timer
	(
		.clk   (clk),
		.rst_b (rst_b),
		.tif   (tif)
	);

	generate
		if (TEST_PINS < 1)
		begin : g_bad
			$error("XNOR chain needs at least one pin");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			present_meta_reg <= 1'b0;
			present_sync_reg <= 1'b0;
			pins_meta_reg    <= '0;
			pins_sync_reg    <= '0;
		end
		else
		begin
			present_meta_reg <= core_rail_present;
			present_sync_reg <= present_meta_reg;
			pins_meta_reg    <= test_pins;
			pins_sync_reg    <= pins_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file; a default load returns both registers to reset values
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dyn_fan_start_temperature_control_one_reg <= crsf_pkg::DYN_FAN_START_TEMPERATURE_CTRL_ONE_RST;
			board_test_enable_reg    <= crsf_pkg::BOARD_TEST_EN_RST;
		end
		else if (load_defaults_reg)
		begin
			dyn_fan_start_temperature_control_one_reg <= crsf_pkg::DYN_FAN_START_TEMPERATURE_CTRL_ONE_RST;
			board_test_enable_reg    <= crsf_pkg::BOARD_TEST_EN_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == crsf_pkg::DYN_FAN_START_TEMPERATURE_CTRL_ONE_OFS)
				dyn_fan_start_temperature_control_one_reg <= reg_wdata;
			if (reg_addr == crsf_pkg::BOARD_TEST_EN_OFS)
				board_test_enable_reg <= reg_wdata;
		end
	end

	// Read data; unmapped offsets read zero
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata_reg <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				crsf_pkg::DYN_FAN_START_TEMPERATURE_CTRL_ONE_OFS: reg_rdata_reg <= dyn_fan_start_temperature_control_one_reg;
				crsf_pkg::BOARD_TEST_EN_OFS:     reg_rdata_reg <= board_test_enable_reg;
				default:                         reg_rdata_reg <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Rail-low condition; it clears itself when the rail recovers
	// gated by enable bit
	assign rail_low_next = dyn_fan_start_temperature_control_one_reg[crsf_pkg::CORE_RAIL_LOW_ENABLE_BIT]
		&& (core_rail_voltage < core_rail_low_limit);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rail_low_reg <= 1'b0;
		else
			rail_low_reg <= rail_low_next;
	end

	// Sticky status flag; a new low event wins over a clear
	// flag rail low
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			status_flag_reg <= 1'b0;
		else if (rail_low_next)
			status_flag_reg <= 1'b1;
		else if (status_clear)
			status_flag_reg <= 1'b0;
	end

	// Alert pulls the open-drain pin low while the flag stands
	// alert if enabled
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			alert_oe_reg <= 1'b0;
		else
			alert_oe_reg <= alert_enable && (status_flag_reg || rail_low_next);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Functions frozen while the rail is low; timer hold keeps the count intact
	// suspend thermal monitoring
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			thermal_en_reg <= 1'b0;
			fan_start_temperature_adj_reg   <= 1'b0;
		end
		else
		begin
			thermal_en_reg <= normal_reg && !rail_low_next;
			fan_start_temperature_adj_reg   <= normal_reg && !rail_low_next;
		end
	end

	// Shutdown entry refused while low; leaving shutdown is always allowed
	// block shutdown entry
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			shutdown_reg <= 1'b0;
		else if (!shutdown_request)
			shutdown_reg <= 1'b0;
		else if (!rail_low_next)
			shutdown_reg <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Board-test XNOR chain over synchronised pins
	// XNOR test mode
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			test_mode_reg <= 1'b0;
			xnor_reg      <= 1'b0;
		end
		else
		begin
			test_mode_reg <= board_test_enable_reg[crsf_pkg::BOARD_TEST_TREE_ENABLE_BIT];
			xnor_reg      <= board_test_enable_reg[crsf_pkg::BOARD_TEST_TREE_ENABLE_BIT]
				&& ~(^pins_sync_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-up sequencer
	always_comb
	begin
		pu_state_next = pu_state_reg;
		unique case (pu_state_reg)
			crsf_pkg::PU_POLL:
			begin
				if (FANS_ON_AT_POWERUP)
					pu_state_next = crsf_pkg::PU_FULL;
				else if (smbus_addr_match)
					pu_state_next = crsf_pkg::PU_NORMAL;
				else if (settle_reg == crsf_pkg::POLL_SETTLE_CYCLES)
					pu_state_next = present_sync_reg ? crsf_pkg::PU_COUNT : crsf_pkg::PU_IDLE;
			end
			crsf_pkg::PU_IDLE:
			begin
				if (smbus_addr_match)
					pu_state_next = crsf_pkg::PU_NORMAL;
			end
			crsf_pkg::PU_COUNT:
			begin
				if (smbus_addr_match)
					pu_state_next = crsf_pkg::PU_NORMAL;
				else if (tif.expired)
					pu_state_next = crsf_pkg::PU_FULL;
			end
			crsf_pkg::PU_FULL:
			begin
				if (smbus_addr_match)
					pu_state_next = crsf_pkg::PU_NORMAL;
			end
			crsf_pkg::PU_NORMAL:
				pu_state_next = crsf_pkg::PU_NORMAL;
			default:
				pu_state_next = crsf_pkg::PU_POLL;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pu_state_reg <= crsf_pkg::PU_POLL;
			settle_reg   <= 2'h0;
		end
		else
		begin
			pu_state_reg <= pu_state_next;
			if (settle_reg != crsf_pkg::POLL_SETTLE_CYCLES)
				settle_reg <= settle_reg + 2'h1;
		end
	end

	// Countdown start on entry, clear on any address
	// start countdown
	assign tif.start = (pu_state_reg == crsf_pkg::PU_POLL) && (pu_state_next == crsf_pkg::PU_COUNT);
	assign tif.clear = smbus_addr_match;

	// Sequencer outputs; defaults load once on the way into normal operation
	// expiry forces full speed
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			full_speed_reg    <= 1'b0;
			load_defaults_reg <= 1'b0;
			normal_reg        <= 1'b0;
		end
		else
		begin
			full_speed_reg    <= (pu_state_next == crsf_pkg::PU_FULL);
			load_defaults_reg <= (pu_state_reg != crsf_pkg::PU_NORMAL)
				&& (pu_state_next == crsf_pkg::PU_NORMAL);
			normal_reg        <= (pu_state_next == crsf_pkg::PU_NORMAL);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output drive
	assign reg_rdata              = reg_rdata_reg;
	assign status_one             = {6'h00, status_flag_reg, 1'b0};
	assign smbus_alert_out        = 1'b0;
	assign smbus_alert_oe         = alert_oe_reg;
	assign thermal_monitor_enable = thermal_en_reg;
	assign thermal_timer_hold     = rail_low_reg;
	assign dyn_fan_start_temperature_adjust_enable = fan_start_temperature_adj_reg;
	assign shutdown_active        = shutdown_reg;
	assign fan_full_speed         = full_speed_reg;
	assign load_defaults          = load_defaults_reg;
	assign normal_operation       = normal_reg;
	assign board_test_mode        = test_mode_reg;
	assign xnor_tree_out          = xnor_reg;

endmodule

/* core/crsf_pkg.sv */
// Constants shared by the core rail supervisor and its fail-safe timer
package crsf_pkg;

	// Register offsets on the internal register port
	localparam logic [7:0] DYN_FAN_START_TEMPERATURE_CTRL_ONE_OFS = 8'h36;
	localparam logic [7:0] BOARD_TEST_EN_OFS     = 8'h6F;

	// Field positions
	localparam int CORE_RAIL_LOW_ENABLE_BIT   = 1;
	localparam int BOARD_TEST_TREE_ENABLE_BIT = 0;
	localparam int STATUS_CORE_RAIL_BIT       = 1;

	// Values after reset and after a default load
	localparam logic [7:0] DYN_FAN_START_TEMPERATURE_CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] BOARD_TEST_EN_RST     = 8'h00;

	// Fail-safe countdown: time as printed, cycles derived from the clock rate
	localparam longint CLK_HZ            = 64'd100_000_000;
	localparam longint FAILSAFE_TIME_MS  = 64'd4600;
	localparam longint FAILSAFE_CYCLES_L = (FAILSAFE_TIME_MS * CLK_HZ) / 64'd1000;
	localparam int     FAILSAFE_CYCLES   = int'(FAILSAFE_CYCLES_L);
	localparam int     FAILSAFE_CNT_W    = 29;

	// Synchroniser settle time before the first rail poll
	localparam logic [1:0] POLL_SETTLE_CYCLES = 2'h3;

	// Power-up sequence states
	typedef enum logic [2:0] {
		PU_POLL   = 3'b000,
		PU_IDLE   = 3'b001,
		PU_COUNT  = 3'b010,
		PU_FULL   = 3'b011,
		PU_NORMAL = 3'b100
	} crsf_pu_state_t;

endpackage

/* core/crsf_timer_if.sv */
// Handshake between the power-up sequencer and the fail-safe countdown
interface crsf_timer_if;
	logic start;    // One-cycle pulse: load and run the countdown
	logic clear;    // One-cycle pulse: abandon the countdown
	logic expired;  // Level: countdown ran out

	modport timer
	(
		input  start,
		input  clear,
		output expired
	);

	modport ctrl
	(
		output start,
		output clear,
		input  expired
	);
endinterface

/* core/crsf_failsafe_timer.sv */
// Fail-safe countdown counter clocked from the internal clock
module crsf_failsafe_timer
#(
	parameter int CYCLES = crsf_pkg::FAILSAFE_CYCLES  // Countdown length in clocks
)
(
	input wire logic      clk,    // System clock
	input wire logic      rst_b,  // Asynchronous reset, active low
	crsf_timer_if.timer   tif     // Start, clear and expiry
);

	logic [crsf_pkg::FAILSAFE_CNT_W-1:0] count_reg;
	logic                                run_reg;
	logic                                expired_reg;

	generate
		if (CYCLES < 1 || longint'(CYCLES) >= (64'd1 << crsf_pkg::FAILSAFE_CNT_W))
		begin : g_bad
			$error("fail-safe cycle count out of range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Countdown; a clear beats a start so an addressed device never re-arms
	// counter clears on address
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count_reg   <= '0;
			run_reg     <= 1'b0;
			expired_reg <= 1'b0;
		end
		else if (tif.clear)
		begin
			count_reg   <= '0;
			run_reg     <= 1'b0;
			expired_reg <= 1'b0;
		end
		else if (tif.start)
		begin
			count_reg   <= crsf_pkg::FAILSAFE_CNT_W'(CYCLES - 1);
			run_reg     <= 1'b1;
			expired_reg <= 1'b0;
		end
		else if (run_reg)
		begin
			if (count_reg == '0)
			begin
				run_reg     <= 1'b0;
				expired_reg <= 1'b1;
			end
			else
			begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	assign tif.expired = expired_reg;

endmodule

/* test/crsf_supervisor_monitor.sv */
// Concurrent checks on the core rail supervisor ports
module crsf_supervisor_monitor
(
	input wire logic       clk,                    // Clock
	input wire logic       rst_b,                  // Reset
	input wire logic       alert_enable,           // Alert source on
	input wire logic       smbus_addr_match,       // Host address
	input wire logic [7:0] status_one,             // Status
	input wire logic       smbus_alert_oe,         // Alert drive
	input wire logic       thermal_monitor_enable, // Monitor on
	input wire logic       thermal_timer_hold,     // Timer frozen
	input wire logic       dyn_fan_start_temperature_adjust_enable, // Adaptation on
	input wire logic       shutdown_active,        // Shutdown
	input wire logic       fan_full_speed,         // Fans forced
	input wire logic       load_defaults,          // Default load
	input wire logic       normal_operation        // Running
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////
	// Rail-low reactions share one cause, so they move together
	a_hold_status: assert property (thermal_timer_hold |-> status_one[crsf_pkg::STATUS_CORE_RAIL_BIT])
		else $error("status flag missing while rail low");
	a_hold_freeze: assert property (thermal_timer_hold |-> !thermal_monitor_enable && !dyn_fan_start_temperature_adjust_enable)
		else $error("monitoring not frozen while rail low");
	// Alert follows the sticky flag, so it may outlive the low condition itself
	a_alert_gate: assert property (smbus_alert_oe |-> $past(alert_enable)
		&& ($past(status_one[crsf_pkg::STATUS_CORE_RAIL_BIT]) || status_one[crsf_pkg::STATUS_CORE_RAIL_BIT]))
		else $error("alert driven without enabled cause");
	a_shut_block: assert property ($rose(shutdown_active) |-> !thermal_timer_hold)
		else $error("shutdown entered while rail low");
	// Both samples of normal taken, so either enable timing passes
	a_resume_all: assert property ($past(normal_operation) && normal_operation && !thermal_timer_hold
		|-> thermal_monitor_enable && dyn_fan_start_temperature_adjust_enable)
		else $error("functions not re-enabled after rail recovery");

	////////////////////////////////////////
	// Power-up fail-safe sequence
	a_fans_addr: assert property (smbus_addr_match && fan_full_speed
		|=> !fan_full_speed && load_defaults && normal_operation)
		else $error("address did not end forced fan speed");
	a_load_pulse: assert property (load_defaults |=> !load_defaults)
		else $error("default load longer than one cycle");
	a_normal_stays: assert property (normal_operation |=> normal_operation)
		else $error("normal operation dropped before reset");
	a_fans_quiet: assert property (fan_full_speed |-> !normal_operation)
		else $error("forced fans during normal operation");

	c_fans: cover property ($rose(fan_full_speed));
	c_hold: cover property ($rose(thermal_timer_hold));
	c_shut: cover property ($rose(shutdown_active));
endmodule

bind crsf_supervisor crsf_supervisor_monitor i_mon
(
	.clk, .rst_b, .alert_enable, .smbus_addr_match, .status_one, .smbus_alert_oe, .thermal_monitor_enable,
	.thermal_timer_hold, .dyn_fan_start_temperature_adjust_enable, .shutdown_active, .fan_full_speed, .load_defaults,
	.normal_operation
);

/* test/crsf_host_model.sv */
// Host and rail model: address pulses and the monitored core rail
module crsf_host_model
(
	input  wire logic clk,          // Bench clock
	output logic      addr_match,   // Valid transaction hit
	output logic      rail_present, // Rail powered
	output logic [7:0] rail_v,      // Rail reading
	output logic [7:0] rail_lim     // Rail low limit
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle host, rail reading above its limit, rail not present
	initial
	begin
		addr_match = 1'b0;
		rail_present = 1'b0;
		rail_v = 8'h80;
		rail_lim = 8'h40;
	end

	task automatic address();
		@(negedge clk);
		addr_match = 1'b1;
		@(negedge clk);
		addr_match = 1'b0;
	endtask

	// Rail moves off the sampling edge only
	task automatic set_rail(input logic [7:0] v, input logic p);
		@(negedge clk);
		rail_v = v;
		rail_present = p;
	endtask
endmodule

/* test/crsf_supervisor_tb_top.sv */
// Self-checking bench for the core rail supervisor
module crsf_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int FS = 20;  // Shortened countdown keeps the run brief
	logic       clk, rst_b, reg_wr, reg_rd, status_clear, alert_enable, shutdown_request;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, status_one, test_pins, rail_v, rail_lim;
	logic       alert_out, alert_oe, mon_en, t_hold, dyn_en, shut, fan, load;
	logic       normal, mode, tree, addr_match, rail_present, fan2;
	int         failures, check_count;

	crsf_host_model i_host (.clk, .addr_match, .rail_present, .rail_v, .rail_lim);
	crsf_supervisor #(.FAILSAFE_CYCLES(FS)) i_dut
	(
		.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .status_clear, .alert_enable,
		.shutdown_request, .test_pins, .status_one, .smbus_alert_out(alert_out), .smbus_alert_oe(alert_oe),
		.smbus_addr_match(addr_match), .core_rail_voltage(rail_v), .core_rail_low_limit(rail_lim),
		.core_rail_present(rail_present), .thermal_monitor_enable(mon_en), .thermal_timer_hold(t_hold),
		.dyn_fan_start_temperature_adjust_enable(dyn_en), .shutdown_active(shut), .fan_full_speed(fan),
		.load_defaults(load), .normal_operation(normal), .board_test_mode(mode), .xnor_tree_out(tree)
	);

	// Build option that starts with fans running; only its fan output is judged
	crsf_supervisor #(.FANS_ON_AT_POWERUP(1'b1), .FAILSAFE_CYCLES(FS)) i_dut_fan
	(
		.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata(), .status_clear, .alert_enable,
		.shutdown_request, .test_pins, .status_one(), .smbus_alert_out(), .smbus_alert_oe(),
		.smbus_addr_match(addr_match), .core_rail_voltage(rail_v), .core_rail_low_limit(rail_lim),
		.core_rail_present(rail_present), .thermal_monitor_enable(), .thermal_timer_hold(),
		.dyn_fan_start_temperature_adjust_enable(), .shutdown_active(), .fan_full_speed(fan2),
		.load_defaults(), .normal_operation(), .board_test_mode(), .xnor_tree_out()
	);

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////
	// Verdict and the shared helpers
	task automatic end_sim();
		if (failures == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// Read data lands on the edge after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk("reg_rdata", exp, reg_rdata);
	endtask

	// Reset spans 16 cycles including the rail setup
	task automatic do_reset(input logic present);
		rst_b = 1'b0;
		i_host.set_rail(8'h80, present);
		repeat (15) @(negedge clk);
		rst_b = 1'b1;
	endtask

	////////////////////////////////////////
	// Silent host: countdown runs out, then an address recovers
	task automatic t_failsafe();
		int n;
		rd(8'h36, 8'h00);
		rd(8'h6F, 8'h00);
		repeat (FS - 6) @(negedge clk);
		chk("fan", 8'h00, 8'(fan));
		for (n = 0; n < 40 && fan !== 1'b1; n++)
			@(negedge clk);
		chk("fan", 8'h01, 8'(fan));
		if (n == 40)
			end_sim();
		wr(8'h36, 8'h02);
		i_host.address();
		chk("fan", 8'h00, 8'(fan));
		chk("load", 8'h01, 8'(load));
		chk("normal", 8'h01, 8'(normal));
		rd(8'h36, 8'h00);
	endtask

	// Register map, unmapped place and the test tree
	task automatic t_regs();
		wr(8'h6F, 8'h01);
		wr(8'h36, 8'h02);
		wr(8'h50, 8'h55);
		rd(8'h6F, 8'h01);
		rd(8'h36, 8'h02);
		rd(8'h50, 8'h00);
		repeat (4) @(negedge clk);
		chk("mode", 8'h01, 8'(mode));
		chk("tree", 8'h01, 8'(tree));
		test_pins = 8'h01;
		repeat (4) @(negedge clk);
		chk("tree", 8'h00, 8'(tree));
		wr(8'h6F, 8'h00);
		repeat (3) @(negedge clk);
		chk("mode", 8'h00, 8'(mode));
	endtask

	// Rail dip with shutdown wanted, recovery, then handling disabled
	task automatic t_rail();
		alert_enable = 1'b1;
		i_host.set_rail(8'h10, 1'b1);
		@(negedge clk);
		chk("status", 8'h02, status_one);
		chk("hold", 8'h01, 8'(t_hold));
		chk("mon_en", 8'h00, 8'(mon_en));
		chk("dyn_en", 8'h00, 8'(dyn_en));
		chk("alert_oe", 8'h01, 8'(alert_oe));
		chk("alert_out", 8'h00, 8'(alert_out));
		shutdown_request = 1'b1;
		alert_enable = 1'b0;
		repeat (3) @(negedge clk);
		chk("shut", 8'h00, 8'(shut));
		chk("alert_oe", 8'h00, 8'(alert_oe));
		i_host.set_rail(8'h80, 1'b1);
		repeat (2) @(negedge clk);
		chk("mon_en", 8'h01, 8'(mon_en));
		chk("dyn_en", 8'h01, 8'(dyn_en));
		chk("shut", 8'h01, 8'(shut));
		chk("status", 8'h02, status_one);
		shutdown_request = 1'b0;
		status_clear = 1'b1;
		@(negedge clk);
		status_clear = 1'b0;
		@(negedge clk);
		chk("status", 8'h00, status_one);
		wr(8'h36, 8'h00);
		i_host.set_rail(8'h10, 1'b1);
		repeat (2) @(negedge clk);
		chk("hold", 8'h00, 8'(t_hold));
		chk("status", 8'h00, status_one);
		i_host.set_rail(8'h80, 1'b1);
	endtask

	// Fresh power-up, rail absent or host early; a later address leaves normal on, loading defaults only when the host was not early
	task automatic t_boot(input logic present, input logic early);
		do_reset(present);
		repeat (5) @(negedge clk);
		chk("fan2", 8'h01, 8'(fan2));
		if (early)
			i_host.address();
		repeat (FS + 40) @(negedge clk);
		chk("fan", 8'h00, 8'(fan));
		chk("normal", 8'(early), 8'(normal));
		i_host.address();
		chk("normal", 8'h01, 8'(normal));
		chk("load", 8'(!early), 8'(load));
		chk("fan2", 8'h00, 8'(fan2));
	endtask

	////////////////////////////////////////
	// Main sequence
	initial
	begin
		{reg_wr, reg_rd, status_clear, alert_enable, shutdown_request} = '0;
		{reg_addr, reg_wdata, test_pins} = '0;
		rst_b = 1'b0;
		failures = 0;
		check_count = 0;
		do_reset(1'b1);
		t_failsafe();
		t_regs();
		t_rail();
		t_boot(1'b0, 1'b0);
		t_boot(1'b1, 1'b1);
		end_sim();
	end
endmodule
